/* File: logic/crs_cfg.svh */
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH

// ==========================================================
// Reset values
// ==========================================================
`define CRS_CC_RESET    8'hE8   // Top three bits and mask set
`define CRS_PC_RESET    16'h0000
`define CRS_SP_HIGH     8'h01   // Forced upper byte of stack
`define CRS_SP_LOW_RST  8'hFF   // Stack top after reset or RSP

// ==========================================================
// Flag positions in the condition flags
// ==========================================================
`define CRS_BIT_H 4
`define CRS_BIT_I 3
`define CRS_BIT_N 2
`define CRS_BIT_Z 1
`define CRS_BIT_C 0

// ==========================================================
// Stack slots, in interrupt push order
// ==========================================================
`define CRS_SLOT_PCL 3'h0
`define CRS_SLOT_PCH 3'h1
`define CRS_SLOT_X   3'h2
`define CRS_SLOT_A   3'h3
`define CRS_SLOT_CC  3'h4

`endif

/* File: logic/crs_pkg.sv */
package crs_pkg;

  // ========================================================
  // Commands from the instruction decoder
  // ========================================================
  typedef enum logic [3:0] {
    CRS_OP_NOP   = 4'h0,
    CRS_OP_LOAD  = 4'h1,  // Plain register write
    CRS_OP_ADD   = 4'h2,
    CRS_OP_ADC   = 4'h3,
    CRS_OP_MOVE  = 4'h4,  // Accumulator load updating N and Z
    CRS_OP_PCINC = 4'h5,
    CRS_OP_JUMP  = 4'h6,
    CRS_OP_BSET  = 4'h7,
    CRS_OP_BCLR  = 4'h8,
    CRS_OP_PSHCC = 4'h9,
    CRS_OP_POPCC = 4'hA,
    CRS_OP_INT   = 4'hB,
    CRS_OP_IRET  = 4'hC,
    CRS_OP_CALL  = 4'hD,
    CRS_OP_RET   = 4'hE,
    CRS_OP_RSP   = 4'hF
  } crs_op_t;

  typedef enum logic [2:0] {
    CRS_SEL_A  = 3'h0,
    CRS_SEL_X  = 3'h1,
    CRS_SEL_Y  = 3'h2,
    CRS_SEL_CC = 3'h3,
    CRS_SEL_S  = 3'h4
  } crs_sel_t;

  typedef enum logic [1:0] {
    CRS_ST_IDLE = 2'b00,
    CRS_ST_PUSH = 2'b01,
    CRS_ST_POP  = 2'b10
  } crs_state_t;

  typedef struct packed {
    crs_op_t     op;
    crs_sel_t    sel;
    logic [2:0]  bit_idx;
    logic [7:0]  data;
    logic [15:0] addr;
  } crs_cmd_t;

  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  idx_x;
    logic [7:0]  idx_y;
    logic [7:0]  condition_flags;
    logic [15:0] program_counter;
    logic [15:0] stack_pointer;
  } crs_regs_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } crs_stk_t;

endpackage

/* File: logic/crs_adder.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Byte adder with flag outputs
// ==========================================================
module crs_adder (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  output logic      [7:0] sum,
  output logic            half,
  output logic            neg,
  output logic            zero,
  output logic            carry
);

  logic [8:0] full;  // Nine bits keep the carry out
  logic [4:0] low;   // Low nibble sum gives the half carry

  // Both sums computed side by side, no ripple sharing needed
  always_comb begin
    full  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    sum   = full[7:0];
    carry = full[8];
    half  = low[4];
    neg   = full[7];
    zero  = (full[7:0] == 8'h00);
  end

endmodule // crs_adder

`default_nettype wire

/* File: logic/crs_core_regs.sv */
// Notes on behaviour
// - Six registers, reached only by commands
// - Eight-bit accumulator for operands and results
// - Two eight-bit index registers
// - Interrupt frames never save second index
// - Program counter holds next instruction address
// - Counter kept as separate low, high bytes
// - Flags register: mask plus four result flags
// - Flags register can be pushed and popped
// - Single flag bits set or cleared alone
// - Interrupt entry sets mask; software clears
// - Half carry from bit three on add
// - Stack decrements after push, increments before pop
// - Interrupt uses five slots, call two
`include "crs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module crs_core_regs (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              cmd_valid,
  input  wire crs_pkg::crs_cmd_t cmd,
  output logic                   cmd_ready,
  output crs_pkg::crs_regs_t     regs,
  output crs_pkg::crs_stk_t      stk,
  input  wire logic [7:0]        stk_rdata
);

  // ========================================================
  // State
  // ========================================================
  logic [7:0] acc, next_acc;          // Accumulator
  logic [7:0] idx_x, next_idx_x;      // First index
  logic [7:0] idx_y, next_idx_y;      // Second index
  logic [7:0] cc, next_cc;            // Condition flags
  logic [7:0] counter_low_byte, next_pcl;          // Counter low byte
  logic [7:0] counter_high_byte, next_pch;          // Counter high byte
  logic [7:0] sp_lo, next_sp_lo;      // Only the low byte moves
  logic [2:0] slot, next_slot;        // Current stack slot
  logic [2:0] slot_end, next_slot_end;
  logic       is_int, next_is_int;    // Frame is an interrupt
  logic [15:0] target, next_target;   // Counter after the frame
  crs_pkg::crs_state_t state, next_state;

  logic [7:0] add_sum;
  logic       add_h;
  logic       add_n;
  logic       add_z;
  logic       add_c;
  logic       take;                   // Command accepted this cycle
  logic [7:0] slot_byte;              // Byte for the current slot
  logic [7:0] sp_inc;                 // Pop address low byte

  assign cmd_ready = (state == crs_pkg::CRS_ST_IDLE);
  assign take      = cmd_valid && cmd_ready;
  assign sp_inc    = sp_lo + 8'h01;

  // ========================================================
  // Arithmetic
  // ========================================================
  crs_adder u_adder (
    .a     (acc),
    .b     (cmd.data),
    .cin   (cmd.op == crs_pkg::CRS_OP_ADC && cc[`CRS_BIT_C]),
    .sum   (add_sum),
    .half  (add_h),
    .neg   (add_n),
    .zero  (add_z),
    .carry (add_c)
  );

  // Byte selected for a push
  always_comb begin
    case (slot)
      `CRS_SLOT_PCL: slot_byte = counter_low_byte;
      `CRS_SLOT_PCH: slot_byte = counter_high_byte;
      `CRS_SLOT_X:   slot_byte = idx_x;
      `CRS_SLOT_A:   slot_byte = acc;
      default:       slot_byte = cc;
    endcase
  end

  // ========================================================
  // Next values
  // ========================================================
  always_comb begin
    next_acc      = acc;
    next_idx_x    = idx_x;
    next_idx_y    = idx_y;
    next_cc       = cc;
    next_pcl      = counter_low_byte;
    next_pch      = counter_high_byte;
    next_sp_lo    = sp_lo;
    next_slot     = slot;
    next_slot_end = slot_end;
    next_is_int   = is_int;
    next_target   = target;
    next_state    = state;
    stk           = '0;
    case (state)
      crs_pkg::CRS_ST_IDLE: begin
        if (take) begin
          case (cmd.op)
            crs_pkg::CRS_OP_LOAD: begin
              case (cmd.sel)
                crs_pkg::CRS_SEL_A:  next_acc = cmd.data;
                crs_pkg::CRS_SEL_X:  next_idx_x = cmd.data;
                crs_pkg::CRS_SEL_Y:  next_idx_y = cmd.data;
                crs_pkg::CRS_SEL_CC: next_cc = cmd.data;
                crs_pkg::CRS_SEL_S:  next_sp_lo = cmd.data;
                default: ;                    // Unknown target ignored
              endcase
            end
            crs_pkg::CRS_OP_ADD, crs_pkg::CRS_OP_ADC: begin
              next_acc              = add_sum;
              next_cc[`CRS_BIT_H]   = add_h;
              next_cc[`CRS_BIT_N]   = add_n;
              next_cc[`CRS_BIT_Z]   = add_z;
              next_cc[`CRS_BIT_C]   = add_c;
            end
            crs_pkg::CRS_OP_MOVE: begin
              next_acc            = cmd.data;
              next_cc[`CRS_BIT_N] = cmd.data[7];
              next_cc[`CRS_BIT_Z] = (cmd.data == 8'h00);
            end
            crs_pkg::CRS_OP_PCINC:
              {next_pch, next_pcl} = {counter_high_byte, counter_low_byte} + 16'h0001;
            crs_pkg::CRS_OP_JUMP:
              {next_pch, next_pcl} = cmd.addr;
            crs_pkg::CRS_OP_BSET: next_cc[cmd.bit_idx] = 1'b1;
            crs_pkg::CRS_OP_BCLR: next_cc[cmd.bit_idx] = 1'b0;
            crs_pkg::CRS_OP_PSHCC: begin
              // Lone flags push; target keeps the counter as is
              next_state    = crs_pkg::CRS_ST_PUSH;
              next_slot     = `CRS_SLOT_CC;
              next_slot_end = `CRS_SLOT_CC;
              next_is_int   = 1'b0;
              next_target   = {counter_high_byte, counter_low_byte};
            end
            crs_pkg::CRS_OP_POPCC: begin
              next_state    = crs_pkg::CRS_ST_POP;
              next_slot     = `CRS_SLOT_CC;
              next_slot_end = `CRS_SLOT_CC;
            end
            crs_pkg::CRS_OP_INT: begin
              // Five slots: counter, index X, accumulator, flags
              next_state    = crs_pkg::CRS_ST_PUSH;
              next_slot     = `CRS_SLOT_PCL;
              next_slot_end = `CRS_SLOT_CC;
              next_is_int   = 1'b1;
              next_target   = cmd.addr;
            end
            crs_pkg::CRS_OP_CALL: begin
              next_state    = crs_pkg::CRS_ST_PUSH;
              next_slot     = `CRS_SLOT_PCL;
              next_slot_end = `CRS_SLOT_PCH;
              next_is_int   = 1'b0;
              next_target   = cmd.addr;
            end
            crs_pkg::CRS_OP_IRET: begin
              next_state    = crs_pkg::CRS_ST_POP;
              next_slot     = `CRS_SLOT_CC;
              next_slot_end = `CRS_SLOT_PCL;
            end
            crs_pkg::CRS_OP_RET: begin
              next_state    = crs_pkg::CRS_ST_POP;
              next_slot     = `CRS_SLOT_PCH;
              next_slot_end = `CRS_SLOT_PCL;
            end
            crs_pkg::CRS_OP_RSP: next_sp_lo = `CRS_SP_LOW_RST;
            default: ;                                   // No operation
          endcase
        end
      end
      crs_pkg::CRS_ST_PUSH: begin
        // Write at the free slot, then step down; wraps silently
        stk.we     = 1'b1;
        stk.addr   = {`CRS_SP_HIGH, sp_lo};
        stk.wdata  = slot_byte;
        next_sp_lo = sp_lo - 8'h01;
        if (slot == slot_end) begin
          next_state           = crs_pkg::CRS_ST_IDLE;
          {next_pch, next_pcl} = target;
          // Mask set after the flags went out, so the saved copy
          // still holds the interrupted level
          if (is_int) next_cc[`CRS_BIT_I] = 1'b1;
        end else begin
          next_slot = slot + 3'h1;
        end
      end
      crs_pkg::CRS_ST_POP: begin
        // Step up first, then read; data must be valid this cycle
        stk.re     = 1'b1;
        stk.addr   = {`CRS_SP_HIGH, sp_inc};
        next_sp_lo = sp_inc;
        case (slot)
          `CRS_SLOT_PCL: next_pcl = stk_rdata;
          `CRS_SLOT_PCH: next_pch = stk_rdata;
          `CRS_SLOT_X:   next_idx_x = stk_rdata;
          `CRS_SLOT_A:   next_acc = stk_rdata;
          default:       next_cc = stk_rdata;
        endcase
        if (slot == slot_end) next_state = crs_pkg::CRS_ST_IDLE;
        else next_slot = slot - 3'h1;
      end
      default: next_state = crs_pkg::CRS_ST_IDLE;
    endcase
  end

  // ========================================================
  // Registers
  // ========================================================
  // Index Y has no slot, so frames cannot reach it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc      <= 8'h00;
      idx_x    <= 8'h00;
      idx_y    <= 8'h00;
      cc       <= `CRS_CC_RESET;
      {counter_high_byte, counter_low_byte} <= `CRS_PC_RESET;
      sp_lo    <= `CRS_SP_LOW_RST;
      slot     <= 3'h0;
      slot_end <= 3'h0;
      is_int   <= 1'b0;
      target   <= 16'h0000;
      state    <= crs_pkg::CRS_ST_IDLE;
    end else begin
      acc      <= next_acc;
      idx_x    <= next_idx_x;
      idx_y    <= next_idx_y;
      cc       <= next_cc;
      counter_low_byte      <= next_pcl;
      counter_high_byte      <= next_pch;
      sp_lo    <= next_sp_lo;
      slot     <= next_slot;
      slot_end <= next_slot_end;
      is_int   <= next_is_int;
      target   <= next_target;
      state    <= next_state;
    end
  end

  assign regs.acc             = acc;
  assign regs.idx_x           = idx_x;
  assign regs.idx_y           = idx_y;
  assign regs.condition_flags = cc;
  assign regs.program_counter = {counter_high_byte, counter_low_byte};
  assign regs.stack_pointer   = {`CRS_SP_HIGH, sp_lo};

  // ========================================================
  // Assertions
  // ========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_take_int;
    take && cmd.op == crs_pkg::CRS_OP_INT;
  endsequence
  sequence s_take_call;
    take && cmd.op == crs_pkg::CRS_OP_CALL;
  endsequence

  a_sp_push_down: assert property (
    stk.we |=> sp_lo == $past(sp_lo) - 8'h01)
    else $error("stack pointer did not step down on push");
  a_sp_pop_up: assert property (
    stk.re |-> stk.addr[7:0] == sp_lo + 8'h01 ##1
      sp_lo == $past(stk.addr[7:0]))
    else $error("stack pointer did not step up before pop");
  a_int_five_slots: assert property (
    s_take_int |=> stk.we [*5] ##1 !stk.we)
    else $error("interrupt frame is not five bytes");
  a_call_two_slots: assert property (
    s_take_call |=> stk.we [*2] ##1 (!stk.we && cmd_ready))
    else $error("call frame is not two bytes");
  a_int_sets_mask: assert property (
    s_take_int ##1 1'b1 [*4] ##1 1'b1 |=> cc[`CRS_BIT_I])
    else $error("mask not set after interrupt entry");
  a_y_kept: assert property (
    !cmd_ready |=> $stable(idx_y))
    else $error("second index changed by a frame");
  a_bit_alone: assert property (
    take && cmd.op == crs_pkg::CRS_OP_BSET |=>
      cc == ($past(cc) | (8'h01 << $past(cmd.bit_idx))))
    else $error("bit set touched other flags");
  a_half_carry: assert property (
    take && cmd.op == crs_pkg::CRS_OP_ADD |=> cc[`CRS_BIT_H] ==
      $past(({1'b0, acc[3:0]} + {1'b0, cmd.data[3:0]}) > 5'h0F))
    else $error("half carry wrong after add");
  a_pc_step: assert property (
    take && cmd.op == crs_pkg::CRS_OP_PCINC |=>
      regs.program_counter == $past(regs.program_counter) + 16'h0001)
    else $error("program counter did not advance by one");

endmodule // crs_core_regs

`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  // ========================================================
  // Signals around the register set
  // ========================================================
  logic               clk;          // 125 MHz core clock
  logic               nrst;         // Async reset, active low
  logic               cmd_valid;    // Command strobe
  logic               cmd_ready;    // Core idle
  crs_pkg::crs_cmd_t  cmd;          // Command fields
  crs_pkg::crs_regs_t regs;         // Register outputs
  crs_pkg::crs_stk_t  stk;          // Stack RAM port
  logic [7:0]         stk_rdata;    // Stack RAM read data
  logic [7:0]         mem [0:255];  // Stack page model
  int                 n_fail = 0;   // Mismatches
  int                 total_checks = 0;
  int                 n_cyc = 0;    // Cycles since start
  int                 n_wr = 0;     // Stack bytes written

  crs_core_regs dut (
    .clk       (clk),
    .nrst      (nrst),
    .cmd_valid (cmd_valid),
    .cmd       (cmd),
    .cmd_ready (cmd_ready),
    .regs      (regs),
    .stk       (stk),
    .stk_rdata (stk_rdata)
  );

  // ========================================================
  // Clock, stack RAM and hang guard
  // ========================================================
  // Clock toggles every half period
  always #4 clk = ~clk;

  // Read data is only valid with the read strobe; otherwise the
  // inverse is shown so a stale value cannot pass by luck
  assign stk_rdata = stk.re ? mem[stk.addr[7:0]] : ~mem[stk.addr[7:0]];

  // Stack page write port
  always @(posedge clk) begin
    if (stk.we === 1'b1) begin
      mem[stk.addr[7:0]] <= stk.wdata;
      n_wr <= n_wr + 1;
    end
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 3000) begin
      $display("Error timeout expected %0d seen %0d", 3000, n_cyc);
      n_fail++;
      print_verdict();
    end
  end

  // ========================================================
  // Tasks
  // ========================================================
  // Compare one value and count it
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // Issue one command and wait until the core is idle again
  task automatic send(input logic [3:0] o, input logic [2:0] s,
                      input logic [2:0] b, input logic [7:0] d,
                      input logic [15:0] a);
    int k;
    cmd_valid = 1'b1;
    cmd.op = crs_pkg::crs_op_t'(o);
    cmd.sel = crs_pkg::crs_sel_t'(s);
    cmd.bit_idx = b;
    cmd.data = d;
    cmd.addr = a;
    // Held until an edge that sees ready high
    for (k = 0; k < 20 && cmd_ready !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd.op = crs_pkg::CRS_OP_NOP;
    // At least one edge passes with valid low, so the next call
    // never raises it in the step that lowered it; frame
    // commands keep the core busy for a few cycles more
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (k < 20 && cmd_ready !== 1'b1);
    // A frame that never ends counts as a mismatch
    chk("ready", 16'h0001, {15'h0000, cmd_ready});
  endtask

  // Plain register write
  task automatic ld(input logic [2:0] s, input logic [7:0] d);
    send(4'h1, s, 3'h0, d, 16'h0000);
  endtask

  // Counts, verdict and end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ========================================================
  // Main sequence
  // ========================================================
  initial begin
    int i;
    int w0;
    logic [7:0] e;
    clk = 1'b0;
    nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    repeat (3) @(posedge clk);
    #1;
    nrst = 1'b1;
    // Reset state: only defined flag bits are compared
    chk("flags_rst", 16'h00E8, regs.condition_flags & 8'hE8);
    chk("pc_rst", 16'h0000, regs.program_counter);
    chk("sp_rst", 16'h01FF, regs.stack_pointer);
    chk("acc_rst", 16'h0000, regs.acc);
    chk("ready_rst", 16'h0001, cmd_ready);
    chk("stk_rst", 16'h0000, {14'h0000, stk.we, stk.re});
    // Accumulator, both indices and flags each written alone
    ld(3'h0, 8'h11);
    ld(3'h1, 8'h22);
    ld(3'h2, 8'h33);
    ld(3'h3, 8'hE0);
    chk("acc", 16'h0011, regs.acc);
    chk("idx_x", 16'h0022, regs.idx_x);
    chk("idx_y", 16'h0033, regs.idx_y);
    chk("flags", 16'h00E0, regs.condition_flags);
    // Unknown load target and no-operation leave all registers
    ld(3'h5, 8'h77);
    send(4'h0, 3'h0, 3'h0, 8'h55, 16'h4321);
    chk("bad_sel_acc", 16'h0011, regs.acc);
    chk("bad_sel_x", 16'h0022, regs.idx_x);
    chk("bad_sel_y", 16'h0033, regs.idx_y);
    chk("bad_sel_sp", 16'h01FF, regs.stack_pointer);
    chk("nop_flags", 16'h00E0, regs.condition_flags);
    chk("nop_pc", 16'h0000, regs.program_counter);
    // Half carry, zero and carry from the adder
    ld(3'h0, 8'h0F);
    send(4'h2, 3'h0, 3'h0, 8'h01, 16'h0000);
    chk("add_acc", 16'h0010, regs.acc);
    chk("add_flags", 16'h00F0, regs.condition_flags);
    ld(3'h0, 8'h80);
    send(4'h2, 3'h0, 3'h0, 8'h80, 16'h0000);
    chk("add_zc", 16'h00E3, regs.condition_flags);
    ld(3'h0, 8'h0F);
    send(4'h3, 3'h0, 3'h0, 8'h00, 16'h0000);
    chk("adc_acc", 16'h0010, regs.acc);
    chk("adc_flags", 16'h00F0, regs.condition_flags);
    send(4'h4, 3'h0, 3'h0, 8'h80, 16'h0000);
    chk("move_flags", 16'h00F4, regs.condition_flags);
    // Single bits set then cleared, others untouched
    ld(3'h3, 8'hE0);
    for (i = 0; i < 5; i++) begin
      e = 8'hE0 | (8'h01 << i);
      send(4'h7, 3'h0, i[2:0], 8'h00, 16'h0000);
      chk("bit_set", {8'h00, e}, regs.condition_flags);
      send(4'h8, 3'h0, i[2:0], 8'h00, 16'h0000);
      chk("bit_clr", 16'h00E0, regs.condition_flags);
    end
    // Low byte carries into high byte
    send(4'h6, 3'h0, 3'h0, 8'h00, 16'h12FF);
    send(4'h5, 3'h0, 3'h0, 8'h00, 16'h0000);
    chk("pc_inc", 16'h1300, regs.program_counter);
    // Interrupt frame: five bytes, mask set, second index kept
    ld(3'h0, 8'hA1);
    ld(3'h1, 8'hB2);
    ld(3'h2, 8'hC3);
    ld(3'h3, 8'hE5);
    send(4'h6, 3'h0, 3'h0, 8'h00, 16'h1234);
    send(4'hF, 3'h0, 3'h0, 8'h00, 16'h0000);
    w0 = n_wr;
    send(4'hB, 3'h0, 3'h0, 8'h00, 16'hABCD);
    chk("int_bytes", 16'h0005, 16'(n_wr - w0));
    chk("int_sp", 16'h01FA, regs.stack_pointer);
    chk("int_pcl", 16'h0034, mem[8'hFF]);
    chk("int_pch", 16'h0012, mem[8'hFE]);
    chk("int_x", 16'h00B2, mem[8'hFD]);
    chk("int_a", 16'h00A1, mem[8'hFC]);
    chk("int_cc", 16'h00E5, mem[8'hFB]);
    chk("int_pc", 16'hABCD, regs.program_counter);
    chk("int_mask", 16'h00ED, regs.condition_flags);
    chk("int_y", 16'h00C3, regs.idx_y);
    // Return from interrupt restores context, mask from stack
    ld(3'h0, 8'h00);
    ld(3'h1, 8'h00);
    ld(3'h2, 8'h5C);
    send(4'hC, 3'h0, 3'h0, 8'h00, 16'h0000);
    chk("iret_a", 16'h00A1, regs.acc);
    chk("iret_x", 16'h00B2, regs.idx_x);
    chk("iret_y", 16'h005C, regs.idx_y);
    chk("iret_cc", 16'h00E5, regs.condition_flags);
    chk("iret_pc", 16'h1234, regs.program_counter);
    chk("iret_sp", 16'h01FF, regs.stack_pointer);
    // Subroutine call uses two bytes
    send(4'h6, 3'h0, 3'h0, 8'h00, 16'h2000);
    w0 = n_wr;
    send(4'hD, 3'h0, 3'h0, 8'h00, 16'h3456);
    chk("call_bytes", 16'h0002, 16'(n_wr - w0));
    chk("call_sp", 16'h01FD, regs.stack_pointer);
    chk("call_ret", 16'h2000, {mem[8'hFE], mem[8'hFF]});
    chk("call_pc", 16'h3456, regs.program_counter);
    send(4'hE, 3'h0, 3'h0, 8'h00, 16'h0000);
    chk("ret_pc", 16'h2000, regs.program_counter);
    chk("ret_sp", 16'h01FF, regs.stack_pointer);
    // Flags saved, overwritten and restored
    send(4'h9, 3'h0, 3'h0, 8'h00, 16'h0000);
    chk("push_sp", 16'h01FE, regs.stack_pointer);
    ld(3'h3, 8'hE8);
    send(4'hA, 3'h0, 3'h0, 8'h00, 16'h0000);
    chk("pop_cc", 16'h00E5, regs.condition_flags);
    chk("pop_sp", 16'h01FF, regs.stack_pointer);
    // Bottom of the page wraps to the top silently
    ld(3'h4, 8'h00);
    chk("sp_low", 16'h0100, regs.stack_pointer);
    send(4'h9, 3'h0, 3'h0, 8'h00, 16'h0000);
    chk("sp_wrap", 16'h01FF, regs.stack_pointer);
    chk("wrap_byte", 16'h00E5, mem[8'h00]);
    // Reset in mid-run brings accumulator, counter, flags and stack pointer back
    nrst = 1'b0;
    #1;
    chk("acc_rst2", 16'h0000, regs.acc);
    chk("pc_rst2", 16'h0000, regs.program_counter);
    chk("flags_rst2", 16'h00E8, regs.condition_flags & 8'hE8);
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk("sp_rst2", 16'h01FF, regs.stack_pointer);
    chk("ready_rst2", 16'h0001, cmd_ready);
    // First command right after release is taken
    ld(3'h1, 8'h5A);
    chk("idx_x_rst2", 16'h005A, regs.idx_x);
    print_verdict();
  end
endmodule // tb_top

`default_nettype wire
